// >>> hdl/ee_pin_ctrl.sv
// Pin-level and power-state controller of a two-wire serial EEPROM target
//
// Behaviour
// - Supply above trigger level: leave reset, enter standby awaiting a command.
// - Supply below trigger level: return to reset state at once.
// - Ready for commands within 1 ms of stable supply.
// - Data line is only pulled low or released, never driven high.
// - Incoming data bits are sampled on the clock's rising edge.
// - Outgoing data bits change only after a falling clock edge.
// - Pulses up to 100 ns on clock and data are ignored.
// - Three address straps form part of the device bus address.
// - An undriven address strap reads as low.
// - Write-protect high refuses every array write; the pin is sampled once per frame, at the end of the word-address acknowledge.
// - An undriven write-protect pin reads as low.
// - Write-protect latched before first data byte; if high, that byte is not acknowledged.
// - During the internal write cycle the data line is released, no response.
// - Respond only to address 1010 plus strap bits plus read/write bit.
// - Acknowledge address and write bytes by holding data low on ninth clock.
`timescale 1ns/1ps
`include "ee_params.svh"

module ee_pin_ctrl #(
  parameter int unsigned PU_CYC = `EE_PU_CYC,   // Power-up to ready, cycles
  parameter int unsigned WR_CYC = `EE_WR_CYC    // Internal write cycle, cycles
) (
  input  wire logic             i_clk,        // System clock, 100 MHz
  input  wire logic             i_rst_n,      // Synchronous reset, active low
  input  wire logic             i_supply_ok,  // Supply above power-on trigger level
  input  wire logic             i_scl,        // Serial clock from controller
  input  wire logic             i_sda_in,     // Serial data line level
  output logic                  o_sda_out,    // Serial data drive value, always low
  output logic                  o_sda_oe,     // Serial data pull-down enable
  input  wire ee_pkg::ee_strap_s i_strap,     // Address and write-protect straps
  input  wire logic [7:0]       i_rd_data,    // Array byte at o_rd_addr
  output logic [7:0]            o_rd_addr,    // Current address pointer
  output ee_pkg::ee_wr_s        o_wr,         // Array write strobe, address, data
  output logic                  o_ready,      // Power-up delay elapsed
  output logic                  o_busy        // Internal write cycle running
);
  import ee_pkg::*;

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  // Final counts of the power-up and write-cycle timers
  localparam logic [19:0] PU_LAST = 20'(PU_CYC - 1);
  localparam logic [19:0] WR_LAST = 20'(WR_CYC - 1);
  // A line level must disagree one cycle longer than this to pass
  localparam logic [3:0]  FILT    = 4'(`EE_FILT_CYC);

  // Whole block state and its next value
  ee_state_s  r;
  ee_state_s  n;
  // Decoded straps and filtered line events
  logic [2:0] strap_a;
  logic       wp_eff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       bus_live;

  // --------------------------------------------------------------------------
  // Strap decode and bus events
  // --------------------------------------------------------------------------
  // Undriven straps fall to the internal pull-down level
  assign strap_a  = i_strap.a_drv & i_strap.a_lvl;
  assign wp_eff   = i_strap.wp_drv & i_strap.wp_lvl;
  // Edges and conditions from the filtered lines only
  assign scl_rise = r.flt[0] & ~r.fd[0];
  assign scl_fall = ~r.flt[0] & r.fd[0];
  assign start_c  = r.flt[0] & r.fd[0] & r.fd[1] & ~r.flt[1];
  assign stop_c   = r.flt[0] & r.fd[0] & ~r.fd[1] & r.flt[1];
  assign bus_live = (r.pwr == EE_PWR_READY) && !r.busy;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    n        = r;
    n.wr.stb = 1'b0;
    n.fd     = r.flt;
    // Noise filters: a level must persist past the filter time to pass
    for (int k = 0; k < 2; k++) begin
      if ((k == 0 ? i_scl : i_sda_in) == r.flt[k]) begin
        n.fcnt[k] = '0;
      end else if (r.fcnt[k] == FILT) begin
        n.flt[k]  = (k == 0) ? i_scl : i_sda_in;
        n.fcnt[k] = '0;
      end else begin
        n.fcnt[k] = r.fcnt[k] + 4'h1;
      end
    end
    // Power sequencing
    case (r.pwr)
      EE_PWR_RESET: begin
        n.pwr = EE_PWR_WAIT;
        n.cnt = '0;
      end
      EE_PWR_WAIT: begin
        if (r.cnt == PU_LAST) begin
          n.pwr = EE_PWR_READY;
          n.cnt = '0;
        end else begin
          n.cnt = r.cnt + 20'h1;
        end
      end
      EE_PWR_READY: begin
        // Internal write cycle timer
        if (r.busy) begin
          if (r.cnt == WR_LAST) begin
            n.busy = 1'b0;
            n.cnt  = '0;
          end else begin
            n.cnt = r.cnt + 20'h1;
          end
        end
      end
      default: n.pwr = EE_PWR_RESET;
    endcase
    // Bus protocol, silent while the write cycle runs
    if (bus_live) begin
      // STOP ends the frame and starts a pending write cycle
      if (stop_c) begin
        n.st     = EE_ST_IDLE;
        n.sda_oe = 1'b0;
        if (r.wrote) begin
          n.busy  = 1'b1;
          n.cnt   = '0;
          n.wrote = 1'b0;
        end
      end else if (start_c) begin
        // START restarts address reception; a pending write stays pending
        n.st        = EE_ST_ADDR;
        n.bitcnt    = '0;
        n.sda_oe    = 1'b0;
        n.got_wa    = 1'b0;
        n.data_seen = 1'b0;
        n.wp_lat    = 1'b0;
      end else begin
        case (r.st)
          EE_ST_IDLE: n.sda_oe = 1'b0;
          EE_ST_ADDR, EE_ST_WDATA: begin
            // Shift on the rise, judge the byte on the fall after bit eight
            if (scl_rise) begin
              n.shreg  = {r.shreg[6:0], r.flt[1]};
              n.bitcnt = r.bitcnt + 4'h1;
            end else if (scl_fall && r.bitcnt == `EE_BITS_BYTE) begin
              n.bitcnt = '0;
              n.st     = EE_ST_IDLE;
              if (r.st == EE_ST_ADDR) begin
                if (r.shreg[7:1] == {`EE_DEV_TYPE, strap_a}) begin
                  n.rw     = r.shreg[0];
                  n.sda_oe = 1'b1;
                  n.st     = EE_ST_ACK;
                end
              end else if (!r.got_wa) begin
                n.ptr    = r.shreg;
                n.got_wa = 1'b1;
                n.sda_oe = 1'b1;
                n.st     = EE_ST_ACK;
              end else if (!r.wp_lat) begin
                n.wr.stb     = 1'b1;
                n.wr.addr    = r.ptr;
                n.wr.data    = r.shreg;
                n.ptr        = {r.ptr[7:4], r.ptr[3:0] + 4'h1};
                n.wrote      = 1'b1;
                n.data_seen  = 1'b1;
                n.sda_oe     = 1'b1;
                n.st         = EE_ST_ACK;
              end
            end
          end
          EE_ST_ACK: begin
            // Acknowledge slot ends on the fall: send read data or receive again
            if (scl_fall) begin
              n.bitcnt = '0;
              if (r.rw) begin
                n.shreg  = i_rd_data;
                n.sda_oe = ~i_rd_data[7];
                n.st     = EE_ST_RDATA;
              end else begin
                n.sda_oe = 1'b0;
                n.st     = EE_ST_WDATA;
                if (r.got_wa && !r.data_seen) begin
                  n.wp_lat = wp_eff;
                end
              end
            end
          end
          EE_ST_RDATA: begin
            // Next bit goes out after each fall, line released after bit eight
            if (scl_rise) begin
              n.bitcnt = r.bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (r.bitcnt == `EE_BITS_BYTE) begin
                n.sda_oe = 1'b0;
                n.ptr    = r.ptr + 8'h1;
                n.st     = EE_ST_RACK;
              end else begin
                n.shreg  = {r.shreg[6:0], 1'b0};
                n.sda_oe = ~r.shreg[6];
              end
            end
          end
          EE_ST_RACK: begin
            // Controller answer: a low level asks for another byte
            if (scl_rise) begin
              n.rd_more = ~r.flt[1];
            end else if (scl_fall) begin
              n.bitcnt = '0;
              if (r.rd_more) begin
                n.shreg  = i_rd_data;
                n.sda_oe = ~i_rd_data[7];
                n.st     = EE_ST_RDATA;
              end else begin
                n.st = EE_ST_IDLE;
              end
            end
          end
          default: begin
            n.st     = EE_ST_IDLE;
            n.sda_oe = 1'b0;
          end
        endcase
      end
    end
    // Brown-out clears every bus-facing bit
    if (!i_supply_ok) begin
      n = `EE_STATE_RST;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= `EE_STATE_RST;
    end else begin
      r <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Data value is tied low; only the enable moves, so the pin stays open drain
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = r.sda_oe;
  assign o_rd_addr = r.ptr;
  assign o_wr      = r.wr;
  assign o_ready   = (r.pwr == EE_PWR_READY);
  assign o_busy    = r.busy;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Pin and power checks
  chk_od_low_only: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  chk_por_reset: assert property (!i_supply_ok |=> r.pwr == EE_PWR_RESET && !o_sda_oe)
    else $error("brown-out did not reset the device");
  chk_pu_delay: assert property ($rose(o_ready) |-> $past(r.cnt) == PU_LAST && r.st == EE_ST_IDLE)
    else $error("ready raised at the wrong count");
  // Bus timing and protocol checks
  chk_oe_after_fall: assert property ($rose(o_sda_oe) |-> $past(scl_fall))
    else $error("data pull-down began off a falling clock");
  chk_filter_time: assert property ($changed(r.flt[0]) && $past(i_supply_ok) |-> $past(r.fcnt[0]) == FILT)
    else $error("clock filter passed a short pulse");
  chk_busy_silent: assert property (r.busy |-> !o_sda_oe && r.st == EE_ST_IDLE)
    else $error("device answered during write cycle");
  chk_wp_refuse: assert property (o_wr.stb |-> !r.wp_lat)
    else $error("write strobe while protected");
  chk_addr_ack: assert property (i_supply_ok && bus_live && scl_fall && r.st == EE_ST_ADDR
    && r.bitcnt == `EE_BITS_BYTE && r.shreg[7:1] == {`EE_DEV_TYPE, strap_a}
    |=> o_sda_oe && r.st == EE_ST_ACK)
    else $error("matching address not acknowledged");
  chk_sample_rise: assert property (i_supply_ok && bus_live && scl_rise && r.st == EE_ST_ADDR
    |=> r.shreg[0] == $past(r.flt[1]))
    else $error("bit not sampled on rising clock");
  // Refusal, write-cycle, power-up and acknowledge checks
  chk_wp_nack: assert property (i_supply_ok && bus_live && scl_fall && r.st == EE_ST_WDATA
    && r.bitcnt == `EE_BITS_BYTE && r.wp_lat |=> !o_sda_oe && !o_wr.stb)
    else $error("protected data byte was acknowledged");
  chk_busy_start: assert property ($rose(o_busy) |-> $past(stop_c) && $past(r.wrote))
    else $error("write cycle began without a stop after data");
  chk_ready_quiet: assert property (!o_ready |-> !o_sda_oe && !o_busy)
    else $error("device active before the power-up delay");
  chk_ack_hold: assert property (r.st == EE_ST_ACK |-> o_sda_oe)
    else $error("data line not held low in the answer slot");

  // Main scenarios
  cov_array_write: cover property (o_wr.stb);
  cov_brown_out:   cover property (!i_supply_ok && o_ready);
  cov_read_byte:   cover property (r.st == EE_ST_RACK && scl_fall && r.rd_more);
  cov_write_done:  cover property ($fell(o_busy));
  cov_wp_nack:     cover property (r.st == EE_ST_WDATA && scl_fall && r.wp_lat && r.bitcnt == `EE_BITS_BYTE);

endmodule : ee_pin_ctrl

// >>> hdl/ee_params.svh
// Timing counts, field values and reset values for the EEPROM bus pin controller
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define EE_CLK_NS      10
`define EE_FILT_NS     100
`define EE_FILT_CYC    ((`EE_FILT_NS) / (`EE_CLK_NS))
`define EE_PU_MS       1
`define EE_PU_CYC      ((`EE_PU_MS) * 1000000 / (`EE_CLK_NS))
`define EE_WR_MS       5
`define EE_WR_CYC      ((`EE_WR_MS) * 1000000 / (`EE_CLK_NS))

// ----------------------------------------------------------------------------
// Widths, fields and reset values
// ----------------------------------------------------------------------------
`define EE_CNT_W       20
`define EE_FCNT_W      4
`define EE_DEV_TYPE    4'ha
`define EE_BITS_BYTE   4'h8
`define EE_STATE_RST   '0

`endif

// >>> hdl/ee_pkg.sv
// Types shared by the EEPROM bus pin controller
package ee_pkg;

  // --------------------------------------------------------------------------
  // Power and bus states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EE_PWR_RESET = 2'h0,
    EE_PWR_WAIT  = 2'h1,
    EE_PWR_READY = 2'h3
  } ee_pwr_e;

  typedef enum logic [2:0] {
    EE_ST_IDLE  = 3'h0,
    EE_ST_ADDR  = 3'h1,
    EE_ST_ACK   = 3'h3,
    EE_ST_WDATA = 3'h2,
    EE_ST_RDATA = 3'h6,
    EE_ST_RACK  = 3'h7
  } ee_bus_e;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] a_drv;   // Strap pin is actively driven
    logic [2:0] a_lvl;   // Strap level when driven
    logic       wp_drv;  // Write-protect pin is actively driven
    logic       wp_lvl;  // Write-protect level when driven
  } ee_strap_s;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } ee_wr_s;

  typedef struct packed {
    ee_pwr_e          pwr;
    ee_bus_e          st;
    logic [1:0]       flt;       // Filtered lines, bit0 clock, bit1 data
    logic [1:0]       fd;        // Filtered lines one cycle back
    logic [1:0][3:0]  fcnt;      // Disagreement counters of the filters
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic             rw;
    logic             got_wa;
    logic             data_seen;
    logic             wp_lat;
    logic             wrote;
    logic             rd_more;
    logic             busy;
    logic [19:0]      cnt;
    logic [7:0]       ptr;
    logic             sda_oe;
    ee_wr_s           wr;
  } ee_state_s;

endpackage : ee_pkg

// >>> tb/ee_host_model.sv
// Two-wire bus controller model that drives the clock and the data line
`timescale 1ns/1ps
module ee_host_model (
  input  wire logic i_clk,   // Bench clock
  input  wire logic i_line,  // Resolved data line
  output logic      o_scl,   // Serial clock, idle high
  output logic      o_sda    // Data drive, 1 releases the line
);
  // --------------------------------------------------------------------
  // Bus primitives
  // --------------------------------------------------------------------
  // Lines idle high, clock stands still outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Wait whole clock cycles
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  // One bit slot; g adds 100 ns pulses on the clock and the data line
  task automatic bit_x(input logic b, input logic g, output logic r);
    o_scl <= 1'b0;
    wt(25);
    o_sda <= b;
    wt(15);
    o_scl <= g;
    wt(10);
    o_scl <= 1'b0;
    wt(25);
    o_scl <= 1'b1;
    wt(25);
    r = i_line;
    o_sda <= b ^ g;
    wt(10);
    o_sda <= b;
    wt(15);
  endtask : bit_x

  // Start or repeated start: data falls while clock is high
  task automatic bus_start();
    o_scl <= 1'b0;
    wt(25);
    o_sda <= 1'b1;
    wt(25);
    o_scl <= 1'b1;
    wt(25);
    o_sda <= 1'b0;
    wt(25);
  endtask : bus_start

  // Stop: data rises while clock is high
  task automatic bus_stop();
    o_scl <= 1'b0;
    wt(25);
    o_sda <= 1'b0;
    wt(25);
    o_scl <= 1'b1;
    wt(25);
    o_sda <= 1'b1;
    wt(25);
  endtask : bus_stop

  // Byte out, most significant bit first, then the answer slot
  task automatic put_byte(input logic [7:0] d, input logic g, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], g, r);
    bit_x(1'b1, 1'b0, r);
    ack = ~r;
  endtask : put_byte

  // Byte in, then acknowledge to continue or release to end
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, 1'b0, d[i]);
    bit_x(~more, 1'b0, r);
  endtask : get_byte
endmodule : ee_host_model

// >>> tb/testbench.sv
// Self-checking bench of the EEPROM bus pin controller
`timescale 1ns/1ps
module testbench;
  import ee_pkg::*;
  // --------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------
  localparam int unsigned PU = 50;
  localparam int unsigned WR = 3000;
  logic       clk = 1'b0;
  logic       rst_n, sup, scl, sda_drv, line, sda_out, oe, ready, busy;
  logic       oe_d = 1'b0;
  logic [2:0] eff;
  logic [7:0] rd_data, rd_addr;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic [15:0] wq [$];
  ee_strap_s  strap;
  ee_wr_s     wr;
  int         error_cnt = 0, checked = 0, busy_len = 0, last_len = 0;

  // Clock, wired-and data line and array read port
  always #5 clk = ~clk;
  assign line = sda_drv & ~(oe & ~sda_out);
  assign rd_data = mem[rd_addr];

  ee_host_model host (.i_clk(clk), .i_line(line), .o_scl(scl), .o_sda(sda_drv));
  ee_pin_ctrl #(.PU_CYC(PU), .WR_CYC(WR)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_supply_ok(sup),
    .i_scl(scl), .i_sda_in(line), .o_sda_out(sda_out), .o_sda_oe(oe), .i_strap(strap),
    .i_rd_data(rd_data), .o_rd_addr(rd_addr), .o_wr(wr), .o_ready(ready), .o_busy(busy));
  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Array writes against the queued notes, pin edges, write cycle length
  always @(posedge clk) begin
    if (wr.stb === 1'b1) begin
      mem[wr.addr] <= wr.data;
      if (wq.size() == 0) check("wr_extra", 16'h1, 16'h0); // No write allowed here
      else check("wr_byte", {wr.addr, wr.data}, wq.pop_front()); // Byte and page address
    end
    if (rst_n === 1'b1 && oe !== oe_d) begin
      check("oe_scl_low", 16'(scl), 16'h0); // Output moves in clock low phase
      check("open_drain", 16'(sda_out), 16'h0); // Only pulled low
    end
    oe_d <= oe;
    busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
    if (busy !== 1'b1 && busy_len != 0) last_len <= busy_len;
  end

  // Watchdog that cuts a hang short
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    print_verdict();
  end
  // --------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (ready !== 1'b1 && cnt < 1000) begin
      @(posedge clk);
      cnt++;
    end
  endtask : wait_ready

  task automatic addr_ack(input logic [3:0] ty, input logic [2:0] a, input logic rw, input logic exp);
    logic ack;
    host.bus_start();
    host.put_byte({ty, a, rw}, 1'b0, ack); // Type, straps and direction
    check("addr_ack", 16'(ack), 16'(exp)); // Answer only to own address
  endtask : addr_ack

  task automatic do_write(input logic [7:0] wa, input int n, input logic g, input logic prot);
    logic ack;
    logic [7:0] d, a;
    addr_ack(4'ha, eff, 1'b0, 1'b1);
    host.put_byte(wa, g, ack);
    check("word_ack", 16'(ack), 16'h1); // Held low in ninth slot
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      a = {wa[7:4], wa[3:0] + 4'(i)};
      if (!prot) begin
        wq.push_back({a, d});
        exp_mem[a] = d;
      end
      host.put_byte(d, g, ack); // Short pulses on odd rounds
      check("data_ack", 16'(ack), {15'h0, ~prot}); // Protected byte refused
    end
    host.bus_stop();
  endtask : do_write

  // Main sequence
  initial begin
    logic [7:0] d;
    logic ack;
    int cnt;
    void'($urandom(85915));
    rst_n = 1'b0;
    sup = 1'b1;
    strap = '0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (5) @(posedge clk);
    check("rst_out", {ready, busy, oe, wr.stb, 4'h0, rd_addr}, 16'h0); // All quiet in reset
    rst_n <= 1'b1;
    wait_ready(cnt); // Commands only once ready
    check("pu_delay", 16'(cnt >= PU && cnt <= PU + 4), 16'h1); // Ready delay
    repeat (20) @(posedge clk);
    sup <= 1'b0;
    repeat (3) @(posedge clk);
    check("brownout", {13'h0, ready, oe, busy}, 16'h0); // Supply loss resets
    sup <= 1'b1;
    wait_ready(cnt);
    check("pu_again", 16'(cnt >= PU && cnt <= PU + 4), 16'h1); // Standby after supply
    repeat (20) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h1c : 8'($urandom);
      strap <= {d[7:5], d[4:2], 1'b0, d[1]}; // Undriven protect pin reads low
      eff = d[7:5] & d[4:2]; // Undriven straps read low
      @(posedge clk);
      addr_ack(4'ha, eff ^ 3'(1 << (k % 3)), 1'b0, 1'b0); // Strap mismatch refused
      host.bus_stop();
      addr_ack(4'hb, eff, 1'b0, 1'b0); // Wrong type refused
      host.bus_stop();
      do_write({d[7:4], 4'hf}, 2, k[0], 1'b0); // Page wrap
      addr_ack(4'ha, eff, 1'b0, 1'b0); // Silent while writing
      host.bus_stop();
      cnt = 0;
      while (busy !== 1'b0 && cnt < 5000) begin
        @(posedge clk);
        cnt++;
      end
      repeat (2) @(posedge clk);
      check("wr_cycle", 16'(last_len), 16'(WR)); // Write cycle length
    end
    strap <= 8'h03;
    eff = 3'h0;
    @(posedge clk);
    do_write(8'h40, 1, 1'b0, 1'b1); // Protected write
    repeat (30) @(posedge clk);
    check("wp_idle", 16'(busy), 16'h0); // No write cycle after refusal
    strap <= 8'h00;
    addr_ack(4'ha, 3'h0, 1'b0, 1'b1);
    host.put_byte(8'hff, 1'b0, ack);
    check("rd_word_ack", 16'(ack), 16'h1); // Word address taken
    addr_ack(4'ha, 3'h0, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.get_byte(i < 2, d);
      check("rd_byte", 16'(d), 16'(exp_mem[8'(255 + i)])); // Bits taken and given on edges
    end
    host.bus_stop();
    repeat (20) @(posedge clk);
    check("wq_empty", 16'(wq.size()), 16'h0); // Every noted write seen
    print_verdict();
  end
endmodule : testbench
